/* File: rtl/serial_status_flags_regs.svh */
// Register offsets, field positions, reset values and timing counts of the serial status block.
// Assumes an APB master with 32-bit data and byte addresses on paddr.
// Summary of operation
// R1 - Transmit empty set at reset and load.
// R2 - Transmit empty cleared: status read, data write.
// R3 - Complete set when empty and nothing sending.
// R4 - Complete cleared: status read, then data/enable/break.
// R5 - Receive full set on character transfer.
// R6 - Receive full cleared: status, data, ninth-bit read.
// R7 - Idle set after 10 or 11 high bits.
// R8 - Idle count starts after start or stop.
// R9 - Idle cleared by sequence, once per character.
// R10 - Overrun set on unread data, character dropped.
// R11 - Overrun cleared: status read, data read.
// R12 - Seven start and three bit samples vote.
// R13 - Noise cleared: status read, data read.
// R14 - Framing error on low stop bit.
// R15 - Framing cleared: status read, data read.
// R16 - Parity error on mismatch when enabled.
// R17 - Parity cleared: status read, data read.
// R18 - Status register read-only, writes ignored.
// R19 - Complete interrupt requested when enabled.
// R20 - Clear only flags seen at status read.
`ifndef SERIAL_STATUS_FLAGS_REGS_SVH
`define SERIAL_STATUS_FLAGS_REGS_SVH

`define SSF_OFF_STATUS      8'h00
`define SSF_OFF_DATA        8'h04
`define SSF_OFF_CTRL_TWO    8'h08
`define SSF_OFF_CTRL_THREE  8'h0C
`define SSF_OFF_CTRL_ONE    8'h10
`define SSF_OFF_BAUD        8'h14

`define SSF_BIT_TX_EMPTY    7
`define SSF_BIT_TX_DONE     6
`define SSF_BIT_RX_FULL     5
`define SSF_BIT_IDLE        4
`define SSF_BIT_OVERRUN     3
`define SSF_BIT_NOISE       2
`define SSF_BIT_FRAMING     1
`define SSF_BIT_PARITY      0

`define SSF_BIT_TX_IRQ_EN   6
`define SSF_BIT_TX_ON       3
`define SSF_BIT_BREAK_Q     0
`define SSF_BIT_RX_NINTH    7
`define SSF_BIT_TX_NINTH    6
`define SSF_BIT_CHAR_LEN    4
`define SSF_BIT_IDLE_SEL    2
`define SSF_BIT_PARITY_ON   1
`define SSF_BIT_PARITY_ODD  0

`define SSF_RST_STATUS      8'hC0
`define SSF_RST_BAUD        16'h0001

`define SSF_TICKS_PER_BIT   4'hF
`define SSF_START_FIRST     4'h3
`define SSF_DATA_FIRST      4'h7
`define SSF_SAMPLE_LAST     4'h9
`define SSF_START_SAMPLES   3'h7
`define SSF_BIT_SAMPLES     3'h3
`define SSF_CHAR_BITS_SHORT 4'hA
`define SSF_CHAR_BITS_LONG  4'hB

`endif

/* File: rtl/serial_status_flags_pkg.sv */
// Types shared by the serial status block.
// Assumes nothing of its surroundings.
package serial_status_flags_pkg;
    typedef enum logic [3:0] {
        RX_IDLE  = 4'h1,
        RX_START = 4'h2,
        RX_DATA  = 4'h4,
        RX_STOP  = 4'h8
    } rx_state_e;
endpackage

/* File: rtl/serial_status_flags.sv */
// Serial interface with status flags, an APB register slave, a 16x receiver and a transmitter.
// Assumes rxd comes from another domain; APB runs on clk_sys.
`timescale 1ns/1ns
`include "serial_status_flags_regs.svh"
module serial_status_flags (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rxd,
    output logic             txd,
    output logic             tx_done_irq
);
    logic [7:0]  status;
    logic [7:0]  seen;
    logic        seen_data_rd;
    logic        seen_ninth_rd;
    logic [7:0]  ctrl_two;
    logic [7:0]  ctrl_one;
    logic        tx_ninth;
    logic [15:0] baud_div;
    logic [15:0] baud_cnt;
    logic        tick;
    logic        mapped;
    logic        setup;
    logic        rd_acc;
    logic        wr_acc;
    logic        rd_status;
    logic        rd_data;
    logic        rd_ninth;
    logic        wr_data;
    logic        wr_ctrl_two;
    logic        tx_on_rise;
    logic        break_write;
    logic        char_len;
    logic [3:0]  nbits;
    logic        rx_meta;
    logic        rx_sync;
    serial_status_flags_pkg::rx_state_e rx_state;
    logic [3:0]  rx_tick;
    logic [2:0]  rx_ones;
    logic [3:0]  rx_bit;
    logic [8:0]  rx_shift;
    logic        rx_par;
    logic        rx_noisy;
    logic [8:0]  rx_data;
    logic [2:0]  nsamp;
    logic        sample_now;
    logic        bit_val;
    logic        bit_noisy;
    logic        bit_end;
    logic        rx_done;
    logic        rx_take;
    logic [7:0]  idle_cnt;
    logic        idle_armed;
    logic        idle_hit;
    logic        rx_clr_full;
    logic        tx_busy;
    logic        preamble_pend;
    logic        break_pend;
    logic [8:0]  tx_buf;
    logic [11:0] tx_shift;
    logic [3:0]  tx_bits;
    logic [3:0]  tx_tick;
    logic        tx_load;
    logic        tx_special;
    logic        tx_par;
    logic [7:0]  next_status;
    logic        tc_clear;
    logic        set_overrun;

    assign setup       = psel & ~penable;
    assign pready      = 1'b1;
    assign rd_acc      = psel & penable & ~pwrite;
    assign wr_acc      = psel & penable & pwrite;
    assign mapped      = (paddr == `SSF_OFF_STATUS) | (paddr == `SSF_OFF_DATA)
                       | (paddr == `SSF_OFF_CTRL_TWO) | (paddr == `SSF_OFF_CTRL_THREE)
                       | (paddr == `SSF_OFF_CTRL_ONE) | (paddr == `SSF_OFF_BAUD);
    assign pslverr     = psel & penable & ~mapped;
    assign rd_status   = rd_acc & (paddr == `SSF_OFF_STATUS);
    assign rd_data     = rd_acc & (paddr == `SSF_OFF_DATA);
    assign rd_ninth    = rd_acc & (paddr == `SSF_OFF_CTRL_THREE);
    assign wr_data     = wr_acc & (paddr == `SSF_OFF_DATA);
    assign wr_ctrl_two = wr_acc & (paddr == `SSF_OFF_CTRL_TWO);
    assign tx_on_rise  = wr_ctrl_two & pwdata[`SSF_BIT_TX_ON] & ~ctrl_two[`SSF_BIT_TX_ON];
    assign break_write = wr_ctrl_two & pwdata[`SSF_BIT_BREAK_Q];
    assign char_len    = ctrl_one[`SSF_BIT_CHAR_LEN];
    assign nbits       = char_len ? 4'h9 : 4'h8;

    // Read data is captured in the setup phase; status has no write path.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0;
        end else if (setup && !pwrite) begin
            case (paddr)
                `SSF_OFF_STATUS:     prdata <= {24'h0, status};
                `SSF_OFF_DATA:       prdata <= {24'h0, rx_data[7:0]};
                `SSF_OFF_CTRL_TWO:   prdata <= {24'h0, ctrl_two};
                `SSF_OFF_CTRL_THREE: prdata <= {24'h0, rx_data[8], tx_ninth, 6'h0};
                `SSF_OFF_CTRL_ONE:   prdata <= {24'h0, ctrl_one};
                `SSF_OFF_BAUD:       prdata <= {16'h0, baud_div};
                default:             prdata <= 32'h0;
            endcase
        end
    end

    // R18 writes to status ignored.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_two <= 8'h00;
            ctrl_one <= 8'h00;
            tx_ninth <= 1'b0;
            baud_div <= `SSF_RST_BAUD;
        end else if (wr_acc) begin
            case (paddr)
                `SSF_OFF_CTRL_TWO:   ctrl_two <= pwdata[7:0];
                `SSF_OFF_CTRL_ONE:   ctrl_one <= pwdata[7:0];
                `SSF_OFF_CTRL_THREE: tx_ninth <= pwdata[`SSF_BIT_TX_NINTH];
                `SSF_OFF_BAUD:       baud_div <= pwdata[15:0];
                default:             baud_div <= baud_div;
            endcase
        end
    end

    // Sixteen ticks make one bit time.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            baud_cnt <= 16'h0000;
        end else if (baud_cnt + 16'h0001 >= baud_div) begin
            baud_cnt <= 16'h0000;
        end else begin
            baud_cnt <= baud_cnt + 16'h0001;
        end
    end
    assign tick = (baud_cnt + 16'h0001 >= baud_div);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else begin
            rx_meta <= rxd;
            rx_sync <= rx_meta;
        end
    end

    // R12 seven or three samples per bit.
    assign nsamp      = (rx_state == serial_status_flags_pkg::RX_START) ?
                        `SSF_START_SAMPLES : `SSF_BIT_SAMPLES;
    assign sample_now = tick && (rx_tick <= `SSF_SAMPLE_LAST) &&
                        (rx_tick >= ((rx_state == serial_status_flags_pkg::RX_START) ?
                                     `SSF_START_FIRST : `SSF_DATA_FIRST));
    assign bit_end    = tick && (rx_tick == `SSF_TICKS_PER_BIT);
    assign bit_val    = ({rx_ones, 1'b0} > {1'b0, nsamp});
    assign bit_noisy  = (rx_ones != 3'h0) && (rx_ones != nsamp);
    assign rx_done    = bit_end && (rx_state == serial_status_flags_pkg::RX_STOP);
    assign rx_take    = rx_done && !status[`SSF_BIT_RX_FULL];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_state <= serial_status_flags_pkg::RX_IDLE;
            rx_tick  <= 4'h0;
            rx_ones  <= 3'h0;
            rx_bit   <= 4'h0;
            rx_shift <= 9'h000;
            rx_par   <= 1'b0;
            rx_noisy <= 1'b0;
        end else begin
            if (tick) begin
                rx_tick <= rx_tick + 4'h1;
            end
            if (sample_now && rx_sync) begin
                rx_ones <= rx_ones + 3'h1;
            end
            case (rx_state)
                serial_status_flags_pkg::RX_IDLE: begin
                    if (tick && !rx_sync) begin
                        rx_state <= serial_status_flags_pkg::RX_START;
                        rx_tick  <= 4'h1;
                        rx_ones  <= 3'h0;
                        rx_noisy <= 1'b0;
                        rx_par   <= 1'b0;
                        rx_bit   <= 4'h0;
                    end
                end
                serial_status_flags_pkg::RX_START: begin
                    if (bit_end) begin
                        rx_ones  <= 3'h0;
                        rx_noisy <= bit_noisy;
                        rx_state <= bit_val ? serial_status_flags_pkg::RX_IDLE :
                                              serial_status_flags_pkg::RX_DATA;
                    end
                end
                serial_status_flags_pkg::RX_DATA: begin
                    if (bit_end) begin
                        rx_ones  <= 3'h0;
                        rx_noisy <= rx_noisy | bit_noisy;
                        rx_par   <= rx_par ^ bit_val;
                        rx_shift <= {bit_val, rx_shift[8:1]};
                        rx_bit   <= rx_bit + 4'h1;
                        if (rx_bit + 4'h1 == nbits) begin
                            rx_state <= serial_status_flags_pkg::RX_STOP;
                        end
                    end
                end
                serial_status_flags_pkg::RX_STOP: begin
                    if (bit_end) begin
                        rx_ones  <= 3'h0;
                        rx_state <= serial_status_flags_pkg::RX_IDLE;
                    end
                end
                default: rx_state <= serial_status_flags_pkg::RX_IDLE;
            endcase
        end
    end

    // R10 dropped character keeps old data.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_data <= 9'h000;
        end else if (rx_take) begin
            rx_data <= char_len ? rx_shift : {1'b0, rx_shift[8:1]};
        end
    end

    // R7 R8 idle counted in ticks.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            idle_cnt <= 8'h00;
        end else if (!rx_sync || idle_hit) begin
            idle_cnt <= 8'h00;
        end else if (tick && (ctrl_one[`SSF_BIT_IDLE_SEL] ?
                              (rx_state == serial_status_flags_pkg::RX_IDLE) :
                              (rx_state != serial_status_flags_pkg::RX_START))) begin
            idle_cnt <= idle_cnt + 8'h01;
        end
    end
    assign idle_hit = idle_armed && (idle_cnt ==
                      {(char_len ? `SSF_CHAR_BITS_LONG : `SSF_CHAR_BITS_SHORT), 4'h0});

    // R9 rearmed only by a received character.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            idle_armed <= 1'b0;
        end else if (rx_take) begin
            idle_armed <= 1'b1;
        end else if (idle_hit) begin
            idle_armed <= 1'b0;
        end
    end

    // R20 flags seen at the last status read.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            seen          <= 8'h00;
            seen_data_rd  <= 1'b0;
            seen_ninth_rd <= 1'b0;
        end else if (rd_status) begin
            seen          <= prdata[7:0];
            seen_data_rd  <= 1'b0;
            seen_ninth_rd <= 1'b0;
        end else begin
            if (rd_data) begin
                seen[`SSF_BIT_IDLE:`SSF_BIT_PARITY] <= 5'h00;
                seen_data_rd <= 1'b1;
            end
            if (rd_ninth) begin
                seen_ninth_rd <= 1'b1;
            end
            if (rx_clr_full) begin
                seen[`SSF_BIT_RX_FULL] <= 1'b0;
            end
            if (wr_data) begin
                seen[`SSF_BIT_TX_EMPTY] <= 1'b0;
            end
            if (tc_clear) begin
                seen[`SSF_BIT_TX_DONE] <= 1'b0;
            end
        end
    end

    // R6 ninth-bit mode needs both reads.
    assign rx_clr_full = seen[`SSF_BIT_RX_FULL] &&
                         (char_len ? ((rd_data || seen_data_rd) && (rd_ninth || seen_ninth_rd) &&
                                      (rd_data || rd_ninth))
                                   : rd_data);
    // R4 three ways to clear completion.
    assign tc_clear    = seen[`SSF_BIT_TX_DONE] && (wr_data || tx_on_rise || break_write);
    assign set_overrun = rx_done && status[`SSF_BIT_RX_FULL];

    // Flag updates; a hardware set wins over a software clear, except for completion, where the clear wins.
    always_comb begin
        next_status = status;
        // R2 cleared by status read then data write.
        if (wr_data && seen[`SSF_BIT_TX_EMPTY]) begin
            next_status[`SSF_BIT_TX_EMPTY] = 1'b0;
        end
        // R1 set when the shifter loads buffered data, not a preamble or break.
        if (tx_load && !tx_special) begin
            next_status[`SSF_BIT_TX_EMPTY] = 1'b1;
        end
        if (tc_clear) begin
            next_status[`SSF_BIT_TX_DONE] = 1'b0;
        end
        // R3 set when nothing is being sent.
        if (status[`SSF_BIT_TX_EMPTY] && !tx_busy && !preamble_pend && !break_pend &&
            !tc_clear && !wr_data) begin
            next_status[`SSF_BIT_TX_DONE] = 1'b1;
        end
        if (rx_clr_full) begin
            next_status[`SSF_BIT_RX_FULL] = 1'b0;
        end
        // R11 R13 R15 R17 cleared by data read.
        if (rd_data) begin
            next_status[`SSF_BIT_IDLE:`SSF_BIT_PARITY] =
                status[`SSF_BIT_IDLE:`SSF_BIT_PARITY] & ~seen[`SSF_BIT_IDLE:`SSF_BIT_PARITY];
        end
        // R5 set on transfer to the buffer.
        if (rx_take) begin
            next_status[`SSF_BIT_RX_FULL] = 1'b1;
            // R12 noise set with the full flag.
            next_status[`SSF_BIT_NOISE]   = rx_noisy | bit_noisy;
            // R14 framing error on low stop.
            next_status[`SSF_BIT_FRAMING] = ~bit_val;
            // R16 parity checked when enabled.
            next_status[`SSF_BIT_PARITY]  = ctrl_one[`SSF_BIT_PARITY_ON] &
                                            (rx_par ^ ctrl_one[`SSF_BIT_PARITY_ODD]);
        end
        // R10 overrun set on unread data.
        if (set_overrun) begin
            next_status[`SSF_BIT_OVERRUN] = 1'b1;
        end
        if (idle_hit) begin
            next_status[`SSF_BIT_IDLE] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            status <= `SSF_RST_STATUS;
        end else begin
            status <= next_status;
        end
    end

    // R19 completion interrupt request.
    assign tx_done_irq = status[`SSF_BIT_TX_DONE] & ctrl_two[`SSF_BIT_TX_IRQ_EN];

    // Transmitter: preamble, break, then buffered data, one frame at a time.
    assign tx_special = preamble_pend | break_pend;
    assign tx_load    = !tx_busy && ctrl_two[`SSF_BIT_TX_ON] &&
                        (tx_special || !status[`SSF_BIT_TX_EMPTY]);
    assign tx_par     = ^tx_buf[7:0] ^ (char_len & tx_buf[8]) ^ ctrl_one[`SSF_BIT_PARITY_ODD];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_buf <= 9'h000;
        end else if (wr_data) begin
            tx_buf <= {tx_ninth, pwdata[7:0]};
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            preamble_pend <= 1'b0;
            break_pend    <= 1'b0;
        end else begin
            if (tx_on_rise) begin
                preamble_pend <= 1'b1;
            end else if (tx_load && preamble_pend) begin
                preamble_pend <= 1'b0;
            end
            if (break_write) begin
                break_pend <= 1'b1;
            end else if (tx_load && !preamble_pend && break_pend &&
                         !ctrl_two[`SSF_BIT_BREAK_Q]) begin
                break_pend <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_busy  <= 1'b0;
            tx_shift <= 12'hFFF;
            tx_bits  <= 4'h0;
            tx_tick  <= 4'h0;
        end else if (tx_load) begin
            tx_busy <= 1'b1;
            tx_tick <= 4'h0;
            tx_bits <= char_len ? `SSF_CHAR_BITS_LONG : `SSF_CHAR_BITS_SHORT;
            if (preamble_pend) begin
                tx_shift <= 12'hFFF;
            end else if (break_pend) begin
                tx_shift <= char_len ? 12'h800 : 12'hC00;
                tx_bits  <= (char_len ? `SSF_CHAR_BITS_LONG : `SSF_CHAR_BITS_SHORT) + 4'h1;
            end else if (char_len) begin
                tx_shift <= {2'h3, ctrl_one[`SSF_BIT_PARITY_ON] ? tx_par : tx_buf[8],
                             tx_buf[7:0], 1'b0};
            end else begin
                tx_shift <= {3'h7, ctrl_one[`SSF_BIT_PARITY_ON] ? tx_par : tx_buf[7],
                             tx_buf[6:0], 1'b0};
            end
        end else if (tx_busy && tick) begin
            tx_tick <= tx_tick + 4'h1;
            if (tx_tick == `SSF_TICKS_PER_BIT) begin
                tx_shift <= {1'b1, tx_shift[11:1]};
                tx_bits  <= tx_bits - 4'h1;
                if (tx_bits == 4'h1) begin
                    tx_busy <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            txd <= 1'b1;
        end else begin
            txd <= tx_busy ? tx_shift[0] : 1'b1;
        end
    end
endmodule

/* File: tb/serial_status_flags_assertions.sv */
// Port checker for the serial status block.
// Assumes the baud divisor keeps its reset value, so a bit is 16 clocks.
`timescale 1ns/1ns
module serial_status_flags_assertions (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rxd,
    input wire logic        txd,
    input wire logic        tx_done_irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic mapped;
    assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    sequence access_s;
        psel && penable;
    endsequence
    sequence status_setup_s;
        psel && !penable && !pwrite && paddr == 8'h00;
    endsequence
    a_ready_always: assert property (pready) else $error("pready low");
    a_err_unmapped: assert property (access_s ##0 !mapped |-> pslverr)
        else $error("no error on unmapped access");
    a_err_mapped: assert property (access_s ##0 mapped |-> !pslverr)
        else $error("error on mapped access");
    a_unmapped_zero: assert property (access_s ##0 !mapped && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_high_zero: assert property (access_s ##0 !pwrite && paddr != 8'h14
        |-> prdata[31:8] == 24'h0) else $error("read high bits set");
    a_irq_status: assert property (status_setup_s ##0 tx_done_irq |=> prdata[6])
        else $error("interrupt without complete flag");
    a_irq_disable: assert property (access_s ##0 pwrite && paddr == 8'h08 && !pwdata[6]
        |=> !tx_done_irq) else $error("interrupt while disabled");
    a_bit_width: assert property ($changed(txd) |=> $stable(txd)[*8] ##1 $stable(txd)[*7])
        else $error("transmit bit shorter than 16 clocks");
    a_reset_idle: assert property ($rose(rst_n) |-> txd && !tx_done_irq)
        else $error("outputs not idle after reset");
endmodule
bind serial_status_flags serial_status_flags_assertions chk_u (.clk_sys(clk_sys),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .txd(txd), .tx_done_irq(tx_done_irq));

/* File: tb/serial_link_peer.sv */
// Remote serial device: sends frames on rxd and decodes frames seen on txd.
// Assumes 16 clocks per bit, the reset baud divisor.
`timescale 1ns/1ns
module serial_link_peer (
    input  wire logic       clk_sys,
    input  wire logic       txd,
    output logic            rxd,
    output logic [7:0]      tx_seen
);
    logic [8:0] cap;
    initial begin
        rxd = 1'b1;
        tx_seen = 8'h00;
    end
    // Caller sets stop, parity and one glitch.
    task automatic send(input logic [11:0] bits, input int n, input int glitch);
        for (int i = 0; i < n; i++) begin
            for (int t = 0; t < 16; t++) begin
                @(posedge clk_sys);
                rxd <= (i == glitch && t == 8) ? ~bits[i] : bits[i];
            end
        end
        @(posedge clk_sys);
        rxd <= 1'b1;
    endtask
    initial begin
        forever begin
            @(negedge txd);
            repeat (8) @(posedge clk_sys);
            for (int i = 0; i < 9; i++) begin
                repeat (16) @(posedge clk_sys);
                cap[i] = txd;
            end
            tx_seen = cap[7:0];
        end
    end
endmodule

/* File: tb/serial_status_flags_tb.sv */
// Self-checking bench for the serial status block with a flag model.
// Assumes the reset baud divisor, so one bit lasts 16 clocks.
`timescale 1ns/1ns
module serial_status_flags_tb;
    logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, rxd, txd, tx_done_irq;
    logic        e, nine;
    logic [7:0]  paddr, tx_seen;
    logic [11:0] fb;
    logic [31:0] pwdata, prdata, r, seed;
    int          n_mismatch, total_checks, st, seen, last_rx, d, nb;
    serial_status_flags dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
        .tx_done_irq(tx_done_irq));
    serial_link_peer peer_u (.clk_sys(clk_sys), .txd(txd), .rxd(rxd), .tx_seen(tx_seen));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_mismatch++;
            give_verdict();
        end else begin
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task automatic rd_status;
        apb(1'b0, 8'h00, 32'h0);
        chk(r, st);
        seen = st;
    endtask
    task automatic rd_data(input logic skip);
        apb(1'b0, 8'h04, 32'h0);
        if (!skip) chk(r, last_rx);
        st &= ~(seen & (nine ? 8'h1F : 8'h3F));
    endtask
    task automatic rx_event(input int err, input int dat);
        if (st[5]) st |= 8'h08;
        else begin
            st |= 8'h30 | err;
            last_rx = dat;
        end
    endtask
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        seed = 32'h8272;
        st = 8'hC0;
        nine = 1'b0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_status();
        apb(1'b1, 8'h00, 32'hFF);
        rd_status();
        apb(1'b0, 8'h20, 32'h0);
        chk(r, 32'h0);
        chk(e, 32'h1);
        apb(1'b1, 8'h08, 32'h08);
        repeat (250) @(posedge clk_sys);
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            apb(1'b1, 8'h08, (k == 1) ? 32'h40 : 32'h48);
            rd_status();
            if (k == 0) apb(1'b1, 8'h04, seed & 32'hFF);
            else apb(1'b1, 8'h08, (k == 1) ? 32'h48 : 32'h49);
            st = 8'h80;
            rd_status();
            chk(tx_done_irq, 32'h0);
            if (k == 2) apb(1'b1, 8'h08, 32'h48);
            repeat (400) @(posedge clk_sys);
            st = 8'hC0;
            rd_status();
            chk(tx_done_irq, 32'h1);
            if (k == 0) chk(tx_seen, seed[7:0]);
        end
        for (int c = 0; c < 6; c++) begin
            seed = lfsr(seed);
            nine = (c == 4);
            nb = nine ? 9 : 8;
            d = seed[8:0] & ((1 << nb) - 1);
            if (c == 3) d[7] = ~^d[6:0];
            fb = 12'(d) << 1;
            fb[nb + 1] = (c != 2);
            apb(1'b1, 8'h10, (c == 3) ? 32'h02 : nine ? 32'h10 : (c == 0) ? 32'h04 : 32'h00);
            peer_u.send(fb, nb + 2, (c == 1) ? 3 : -1);
            rx_event((c == 1) ? 4 : (c == 2) ? 2 : (c == 3) ? 1 : 0, d & 8'hFF);
            repeat (200) @(posedge clk_sys);
            rd_status();
            if (c == 5) begin
                peer_u.send(fb & 12'h1FF, 10, -1);
                rx_event(2, 0);
                repeat (200) @(posedge clk_sys);
            end
            rd_data(1'b0);
            if (nine) begin
                apb(1'b0, 8'h0C, 32'h0);
                chk(r, {24'h0, d[8], 7'h0});
                st &= ~(seen & 8'h20);
                rd_status();
            end
            repeat (200) @(posedge clk_sys);
            rd_status();
            if (st != 8'hC0) rd_data(1'b0);
        end
        nine = 1'b0;
        rd_status();
        give_verdict();
    end
endmodule
